// File: vdio_pkg.sv
// Shared constants and carrier types for the virtual digital I/O mapper
package vdio_pkg;

  localparam int N_VIN  = 5;
  localparam int N_VOUT = 5;
  localparam int N_AI   = 3;
  localparam int FUNC_W = 6;
  localparam int N_FUNC = 64;
  localparam int AI_W   = 10;
  localparam int DLY_W  = 16;
  localparam int TICK_W = 24;

  // Analog sample in 10 mV units, so 10.00 V full scale reads 1000
  localparam logic [AI_W-1:0] AI_HI_LEVEL = 10'h2BC;
  localparam logic [AI_W-1:0] AI_LO_LEVEL = 10'h12C;

  // Function codes
  localparam logic [FUNC_W-1:0] FUNC_NONE          = 6'h00;
  localparam logic [FUNC_W-1:0] FUNC_USER_FAULT    = 6'h2C;
  localparam logic [FUNC_W-1:0] FUNC_CURRENT_REACH = 6'h1C;
  localparam logic [FUNC_W-1:0] VOUT_MIRROR_PIN    = 6'h00;

  // Source select per soft input
  localparam logic SRC_LINKED = 1'b0;
  localparam logic SRC_WORD   = 1'b1;

  // Delay time base
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TENTH_S_NS     = 100_000_000;
  localparam int TENTH_S_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;

  // Soft input configuration
  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic              src;
  } vdio_vin_cfg_t;

  // Analog channel used as a digital input
  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic              active_low;
  } vdio_ai_cfg_t;

  // Analog sample carrier
  typedef struct packed {
    logic            valid;
    logic [AI_W-1:0] level;
  } vdio_ai_sample_t;

  // Soft output configuration
  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic              invert;
    logic [DLY_W-1:0]  delay;
  } vdio_vout_cfg_t;

  typedef enum logic [1:0] {
    VDIO_DLY_IDLE = 2'b01,
    VDIO_DLY_WAIT = 2'b10
  } vdio_dly_state_t;

endpackage

// File: vdio_delay.sv
// Per-output change delay counted in tenth-second ticks
`timescale 1ns/1ns
module vdio_delay
  import vdio_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Time base
  input  wire logic             tick,
  // Requested level and delay
  input  wire logic             target,
  input  wire logic [DLY_W-1:0] delay_set,
  // Delayed level
  output logic                  out_r
);

  vdio_dly_state_t  state_r;
  vdio_dly_state_t  state_nxt;
  logic [DLY_W-1:0] cnt_r;
  logic [DLY_W-1:0] cnt_nxt;
  logic             out_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    unique case (state_r)
      VDIO_DLY_IDLE: begin
        if (target != out_r) begin
          if (delay_set == '0) begin
            out_nxt = target;  // [R14]
          end else begin
            cnt_nxt   = '0;
            state_nxt = VDIO_DLY_WAIT;
          end
        end
      end
      VDIO_DLY_WAIT: begin
        // A change withdrawn before expiry never reaches the output
        if (target == out_r) begin
          state_nxt = VDIO_DLY_IDLE;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_nxt >= delay_set) begin
            out_nxt   = target;  // [R14]
            state_nxt = VDIO_DLY_IDLE;
          end
        end
      end
      default: begin
        state_nxt = VDIO_DLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= VDIO_DLY_IDLE;
      cnt_r   <= '0;
      out_r   <= 1'b0;  // [R15]
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
    end
  end

endmodule

// File: vdio_mapper.sv
// Virtual digital input and output mapper top level
`timescale 1ns/1ns
// Function
// R1 - Per soft input: linked output or state word
// R2 - Linked input valid exactly while output active; the code's linked input lags the output by one clock
// R3 - Word source: input follows its own digit
// R4 - Analog channel function code 0..63, default 0
// R5 - Analog above 7V gives high level
// R6 - Analog below 3V gives low level
// R7 - Between thresholds analog level holds
// R8 - Per analog channel polarity: 0 high, 1 low
// R9 - Output code 0 mirrors physical terminal x
// R10 - Output codes nonzero follow matching output function
// R11 - Per output polarity: positive or inverted
// R12 - User fault input plus current reach stops drive
// R13 - Soft inputs carry full input function set
// R14 - Output change delayed by tenth-second setting
// R15 - States clocked synchronously, cleared on reset
module vdio_mapper
  import vdio_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = TENTH_S_CYCLES
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Physical input terminals, asynchronous
  input  wire logic [N_VIN-1:0]      term_pin,
  // Soft input configuration and state word
  input  wire vdio_vin_cfg_t         vin_cfg [N_VIN],
  input  wire logic [N_VIN-1:0]      vin_word,
  // Analog channels used as digital inputs
  input  wire vdio_ai_cfg_t          ai_cfg [N_AI],
  input  wire vdio_ai_sample_t       analog_in_channel [N_AI],
  // Soft output configuration and drive output functions
  input  wire vdio_vout_cfg_t        vout_cfg [N_VOUT],
  input  wire logic [N_FUNC-1:0]     do_func_level,
  // Fault acknowledge from firmware
  input  wire logic                  fault_clear,
  // Derived states
  output logic [N_VIN-1:0]           soft_input_r,
  output logic [N_AI-1:0]            ai_level_r,
  output logic [N_AI-1:0]            ai_active_r,
  output logic [N_VOUT-1:0]          soft_output_r,
  output logic [N_FUNC-1:0]          func_req_r,
  // Fault handling
  output logic                       user_fault_one_r,
  output logic                       drive_stop_r
);

  // One-hot decode of a function code; code 0 selects nothing
  function automatic logic [N_FUNC-1:0] func_onehot(input logic [FUNC_W-1:0] code,
                                                    input logic              act);
    logic [N_FUNC-1:0] v;
    v = '0;
    if (act && code != FUNC_NONE) begin
      v[code] = 1'b1;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Tenth-second time base
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic              tick_r;
  logic              tick_nxt;

  always_comb begin
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    tick_nxt     = 1'b0;
    if (tick_cnt_r >= TICK_W'(TENTH_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Terminal synchronisers: third stage guards against metastable flips
  // ---------------------------------------------------------------
  logic [N_VIN-1:0] sync1_r;
  logic [N_VIN-1:0] sync2_r;
  logic [N_VIN-1:0] sync3_r;
  logic [N_VIN-1:0] term_r;
  logic [N_VIN-1:0] term_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < N_VIN; gi++) begin : g_term
      always_comb begin
        term_nxt[gi] = term_r[gi];
        if (sync2_r[gi] == sync3_r[gi]) begin
          term_nxt[gi] = sync3_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      term_r  <= '0;
    end else begin
      sync1_r <= term_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      term_r  <= term_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Soft inputs
  // ---------------------------------------------------------------
  logic [N_VIN-1:0] soft_input_nxt;

  generate
    for (gi = 0; gi < N_VIN; gi++) begin : g_vin
      always_comb begin
        if (vin_cfg[gi].src == SRC_WORD) begin  // [R1]
          soft_input_nxt[gi] = vin_word[gi];  // [R3]
        end else begin
          soft_input_nxt[gi] = soft_output_r[gi];  // [R2]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_input_r <= '0;  // [R15]
    end else begin
      soft_input_r <= soft_input_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Analog channels as digital inputs
  // ---------------------------------------------------------------
  logic [N_AI-1:0] ai_level_nxt;
  logic [N_AI-1:0] ai_active_nxt;

  generate
    for (gi = 0; gi < N_AI; gi++) begin : g_ai
      always_comb begin
        ai_level_nxt[gi] = ai_level_r[gi];  // [R7]
        if (analog_in_channel[gi].valid) begin
          if (analog_in_channel[gi].level > AI_HI_LEVEL) begin
            ai_level_nxt[gi] = 1'b1;  // [R5]
          end else if (analog_in_channel[gi].level < AI_LO_LEVEL) begin
            ai_level_nxt[gi] = 1'b0;  // [R6]
          end
        end
        ai_active_nxt[gi] = ai_level_nxt[gi] ^ ai_cfg[gi].active_low;  // [R8]
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ai_level_r  <= '0;
      ai_active_r <= '0;
    end else begin
      ai_level_r  <= ai_level_nxt;
      ai_active_r <= ai_active_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Function requests from soft inputs and analog channels
  // ---------------------------------------------------------------
  logic [N_FUNC-1:0] func_req_nxt;

  always_comb begin
    func_req_nxt = '0;
    for (int i = 0; i < N_VIN; i++) begin
      func_req_nxt = func_req_nxt | func_onehot(vin_cfg[i].func, soft_input_r[i]);  // [R13]
    end
    for (int i = 0; i < N_AI; i++) begin
      func_req_nxt = func_req_nxt | func_onehot(ai_cfg[i].func, ai_active_r[i]);  // [R4]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      func_req_r <= '0;
    end else begin
      func_req_r <= func_req_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Soft outputs: source, polarity, then delay
  // ---------------------------------------------------------------
  logic [N_VOUT-1:0] vout_target;

  generate
    for (gi = 0; gi < N_VOUT; gi++) begin : g_vout
      logic raw;
      always_comb begin
        if (vout_cfg[gi].func == VOUT_MIRROR_PIN) begin
          raw = term_r[gi];  // [R9]
        end else begin
          raw = do_func_level[vout_cfg[gi].func];  // [R10]
        end
        vout_target[gi] = raw ^ vout_cfg[gi].invert;  // [R11]
      end

      vdio_delay u_delay (
        .clk       (clk),
        .nrst      (nrst),
        .tick      (tick_r),
        .target    (vout_target[gi]),
        .delay_set (vout_cfg[gi].delay),
        .out_r     (soft_output_r[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // User fault: the loop output -> linked input -> fault function
  // closes here; set wins over a same-cycle clear
  // ---------------------------------------------------------------
  logic user_fault_nxt;

  always_comb begin
    user_fault_nxt = user_fault_one_r;
    if (fault_clear) begin
      user_fault_nxt = 1'b0;
    end
    if (func_req_r[FUNC_USER_FAULT]) begin
      user_fault_nxt = 1'b1;  // [R12]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      user_fault_one_r <= 1'b0;
      drive_stop_r     <= 1'b0;
    end else begin
      user_fault_one_r <= user_fault_nxt;
      drive_stop_r     <= user_fault_nxt;  // [R12]
    end
  end

endmodule

// File: vdio_mapper_assertions.sv
// Concurrent checks on the soft I/O mapper ports
`timescale 1ns/1ns
module vdio_mapper_assertions
  import vdio_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = TENTH_S_CYCLES
)
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // Inputs
  input wire logic [N_VIN-1:0]    term_pin,
  input wire vdio_vin_cfg_t       vin_cfg [N_VIN],
  input wire logic [N_VIN-1:0]    vin_word,
  input wire vdio_ai_cfg_t        ai_cfg [N_AI],
  input wire vdio_ai_sample_t     analog_in_channel [N_AI],
  input wire vdio_vout_cfg_t      vout_cfg [N_VOUT],
  // Outputs
  input wire logic [N_VIN-1:0]    soft_input_r,
  input wire logic [N_AI-1:0]     ai_level_r,
  input wire logic [N_AI-1:0]     ai_active_r,
  input wire logic [N_VOUT-1:0]   soft_output_r,
  input wire logic [N_FUNC-1:0]   func_req_r,
  input wire logic                user_fault_one_r,
  input wire logic                drive_stop_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_rst_clear;
    !$past(nrst) |-> soft_input_r == '0 && soft_output_r == '0 && !user_fault_one_r;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
  property p_word;
    vin_cfg[0].src == SRC_WORD |=> soft_input_r[0] == $past(vin_word[0]);
  endproperty
  a_word: assert property (p_word) else $error("word source wrong");
  property p_link;
    vin_cfg[0].src == SRC_LINKED |=> soft_input_r[0] == $past(soft_output_r[0]);
  endproperty
  a_link: assert property (p_link) else $error("linked source wrong");
  property p_hi;
    analog_in_channel[0].valid && analog_in_channel[0].level > AI_HI_LEVEL |=> ai_level_r[0];
  endproperty
  a_hi: assert property (p_hi) else $error("high level missed");
  property p_lo;
    analog_in_channel[0].valid && analog_in_channel[0].level < AI_LO_LEVEL |=> !ai_level_r[0];
  endproperty
  a_lo: assert property (p_lo) else $error("low level missed");
  property p_hold;
    !analog_in_channel[0].valid || (analog_in_channel[0].level >= AI_LO_LEVEL
      && analog_in_channel[0].level <= AI_HI_LEVEL) |=> $stable(ai_level_r[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("level not held");
  property p_pol;
    $past(nrst) |-> ai_active_r[0] == (ai_level_r[0] ^ $past(ai_cfg[0].active_low));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_fault;
    func_req_r[FUNC_USER_FAULT] |=> user_fault_one_r && drive_stop_r;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not raised");
  property p_req;
    soft_input_r[1] && vin_cfg[1].func != FUNC_NONE |=> func_req_r[$past(vin_cfg[1].func)];
  endproperty
  a_req: assert property (p_req) else $error("function not requested");
  // Pin path includes a three-stage synchroniser
  property p_mirror;
    vout_cfg[1] == '0 && $rose(term_pin[1]) |-> ##[1:10] soft_output_r[1];
  endproperty
  a_mirror: assert property (p_mirror) else $error("pin not mirrored");

  c_fault: cover property (user_fault_one_r);
  c_word: cover property (vin_cfg[0].src == SRC_WORD && soft_input_r[0]);
  c_pol: cover property (ai_level_r[0] && !ai_active_r[0]);
endmodule

bind vdio_mapper vdio_mapper_assertions #(.TENTH_CYCLES(TENTH_CYCLES))
  vdio_mapper_assertions_inst (.clk, .nrst, .term_pin, .vin_cfg, .vin_word, .ai_cfg,
  .analog_in_channel, .vout_cfg, .soft_input_r, .ai_level_r, .ai_active_r,
  .soft_output_r, .func_req_r, .user_fault_one_r, .drive_stop_r);

// File: vdio_partner.sv
// Firmware and terminal model: pin levels and output function levels
`timescale 1ns/1ns
module vdio_partner
  import vdio_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [N_VIN-1:0]  pin_set,
  input  wire logic [N_FUNC-1:0] lvl_set,
  output logic [N_VIN-1:0]       term_pin,
  output logic [N_FUNC-1:0]      do_func_level
);
  // One process owns both outputs; updates land after the edge samples
  initial begin
    term_pin = '0;
    do_func_level = '0;
    forever begin
      @(posedge clk);
      term_pin <= pin_set;
      do_func_level <= lvl_set;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the soft I/O mapper
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench import vdio_pkg::*;;
  logic              clk;
  logic              nrst;
  logic [N_VIN-1:0]  pin_set;
  logic [N_FUNC-1:0] lvl_set;
  logic [N_VIN-1:0]  term_pin;
  logic [N_FUNC-1:0] do_func_level;
  vdio_vin_cfg_t     vin_cfg [N_VIN];
  logic [N_VIN-1:0]  vin_word;
  vdio_ai_cfg_t      ai_cfg [N_AI];
  vdio_ai_sample_t   analog_in_channel [N_AI];
  vdio_vout_cfg_t    vout_cfg [N_VOUT];
  logic              fault_clear;
  logic [N_VIN-1:0]  soft_input_r;
  logic [N_AI-1:0]   ai_level_r;
  logic [N_AI-1:0]   ai_active_r;
  logic [N_VOUT-1:0] soft_output_r;
  logic [N_FUNC-1:0] func_req_r;
  logic              user_fault_one_r;
  logic              drive_stop_r;
  int                failures = 0;
  int                n_tests = 0;
  // Row: level, polarity, expected level, expected active
  logic [12:0]       rows [5];

  vdio_mapper #(.TENTH_CYCLES(4)) vdio_mapper_inst (.clk, .nrst, .term_pin, .vin_cfg,
    .vin_word, .ai_cfg, .analog_in_channel, .vout_cfg, .do_func_level, .fault_clear,
    .soft_input_r, .ai_level_r, .ai_active_r, .soft_output_r, .func_req_r,
    .user_fault_one_r, .drive_stop_r);
  vdio_partner vdio_partner_inst (.clk, .pin_set, .lvl_set, .term_pin, .do_func_level);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic nc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs about 80 cycles
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    pin_set = '0;
    lvl_set = '0;
    vin_word = '0;
    fault_clear = 1'b0;
    rows = '{{10'h2BD, 3'h3}, {10'h2BC, 3'h3}, {10'h12C, 3'h6}, {10'h12B, 3'h5},
             {10'h1F4, 3'h0}};
    for (int i = 0; i < N_VIN; i++) begin
      vin_cfg[i] = '{func: FUNC_NONE, src: SRC_WORD};
      vout_cfg[i] = '{func: VOUT_MIRROR_PIN, invert: 1'b0, delay: '0};
    end
    for (int k = 0; k < N_AI; k++) begin
      ai_cfg[k] = '{func: FUNC_NONE, active_low: 1'b0};
      analog_in_channel[k] = '{valid: 1'b0, level: '0};
    end
    nc(3);
    `CHK("reset", '0, {soft_input_r, ai_level_r, soft_output_r, user_fault_one_r})
    nrst = 1'b1;
    nc(1);
    `CHK("release", '0, {func_req_r, ai_active_r, drive_stop_r})
    $display("test reset done");
    foreach (rows[r]) begin
      for (int k = 0; k < N_AI; k++) begin
        ai_cfg[k] = '{func: 6'h3D + 6'(k), active_low: rows[r][2]};
        analog_in_channel[k] = '{valid: 1'b1, level: rows[r][12:3]};
      end
      nc(1);
      for (int k = 0; k < N_AI; k++) analog_in_channel[k].valid = 1'b0;
      nc(2);
      `CHK("ai_level", {3{rows[r][1]}}, ai_level_r)
      `CHK("ai_active", {3{rows[r][0]}}, ai_active_r)
      `CHK("ai_func", {3{rows[r][0]}}, func_req_r[63:61])
    end
    $display("test analog done");
    for (int i = 0; i < N_VIN; i++) vin_cfg[i].func = 6'(i + 1);
    vin_word = 5'h15;
    nc(3);
    `CHK("word_in", 5'h15, soft_input_r)
    `CHK("word_req", 6'h2A, func_req_r[5:0])
    $display("test word done");
    for (int i = 0; i < N_VIN; i++) begin
      vin_cfg[i].src = SRC_LINKED;
      vout_cfg[i].invert = (i == 4);
    end
    pin_set = 5'h0A;
    nc(10);
    `CHK("mirror", 5'h1A, soft_output_r)
    `CHK("linked", 5'h1A, soft_input_r)
    pin_set = 5'h00;
    nc(10);
    `CHK("mirror_off", 5'h10, soft_output_r)
    `CHK("linked_off", 5'h10, soft_input_r)
    $display("test mirror done");
    for (int i = 1; i < N_VOUT; i++) vout_cfg[i].func = 6'(i);
    lvl_set = 64'h0000_0000_0000_0014;
    nc(4);
    `CHK("do_func", 5'h04, soft_output_r)
    vout_cfg[3].delay = 16'h0002;
    lvl_set = 64'h0000_0000_0000_001C;
    nc(3);
    `CHK("delay_early", 1'b0, soft_output_r[3])
    nc(12);
    `CHK("delay_late", 1'b1, soft_output_r[3])
    $display("test output done");
    vin_cfg[0].func = FUNC_USER_FAULT;
    vout_cfg[0].func = FUNC_CURRENT_REACH;
    lvl_set = 64'h0000_0000_1000_001C;
    nc(8);
    `CHK("fault_set", 2'h3, {user_fault_one_r, drive_stop_r})
    lvl_set = 64'h0000_0000_0000_001C;
    nc(8);
    `CHK("fault_sticky", 2'h3, {user_fault_one_r, drive_stop_r})
    fault_clear = 1'b1;
    nc(2);
    `CHK("fault_clr", 2'h0, {user_fault_one_r, drive_stop_r})
    fault_clear = 1'b0;
    $display("test fault done");
    complete_run;
  end
endmodule
